// File: verilog/sfss_consts.svh
`ifndef SFSS_CONSTS_SVH
`define SFSS_CONSTS_SVH
`define SFSS_ADDR_W 9
`define SFSS_ADDR_OFFSET 9'h0d8
`define SFSS_ADDR_SLIP_STATUS 9'h0d9
`define SFSS_ADDR_SIGCR 9'h0d7
`define SFSS_OFFSET_RST 5'h00
`define SFSS_SIGCR_RST 8'h00
`define SFSS_BIT_TRANSPARENT 0
`define SFSS_BIT_FORCE 1
`define SFSS_BIT_RELEASE 2
`define SFSS_BIT_DEBOUNCE 3
`define SFSS_SS_TX_DIR 7
`define SFSS_SS_TX_CTRL 6
`define SFSS_SS_TX_UNCTRL 5
`define SFSS_SS_RX_DIR 3
`define SFSS_SS_RX_CTRL 2
`define SFSS_SS_RX_UNCTRL 1
`define SFSS_E1_FRAMES 5'h10
`define SFSS_T1_FRAMES 5'h18
`define SFSS_T1_MAX_OFFSET 5'h17
`endif

// File: verilog/sfss_pkg.sv
package sfss_pkg;
	typedef enum logic [1:0]
	{
		SFSS_SB_NORMAL = 2'b00,
		SFSS_SB_SHORT = 2'b01,
		SFSS_SB_ELASTIC = 2'b10,
		SFSS_SB_BYPASS = 2'b11
	} sfss_sb_mode_t;
endpackage

// File: verilog/sfss_core.sv
// Behaviour
// - Without debounce, copy input ABCD at D-bit
// - Freeze controls drive pin and buffer updates, not interrupt
// - Force with release clear: pin high, no buffer updates
// - Release: pin low, all updates, stack-enabled pushes
// - Both zero: pin and updates follow auto freeze
// - Transparent mode aligns multiframe sync to receive timebase
// - Multiframe sync tracks realignment without alarm
// - Offset selects bus frame of multiframe pulse
// - E1 ignores MSB; T1 caps offset at 17h
// - Reinsertion only on insertion-enabled channels
// - Slip status updated at frame boundaries
// - Status bits latch until processor read
// - Transmit direction: 0 deleted, 1 repeated
// - Any transmit or receive slip flag set in slip status raises slip interrupt indication
// - Controlled slip keeps timebase; uncontrolled disturbs it
// - Transmit frame slip zero in bypass; elastic reports uncontrolled slips only
// - Short delay: fast bus uncontrolled, fast line controlled
// - Receive direction: 0 deleted/resync, 1 repeated/reassign
`include "sfss_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module sfss_core
	import sfss_pkg::*;
#(
	parameter int CHANNELS = 32
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [`SFSS_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Configuration from other registers
	input wire logic line_rate_select,
	input wire logic [CHANNELS-1:0] stack_channel_enable,
	input wire logic [CHANNELS-1:0] insert_enable,
	input wire sfss_sb_mode_t tx_bus_config,
	input wire sfss_sb_mode_t rx_system_bus,
	// Receive signaling path
	input wire logic dbit_update,
	input wire logic [4:0] dbit_channel,
	input wire logic [3:0] abcd_in,
	input wire logic auto_freeze,
	output logic signaling_freeze,
	output logic freeze_irq_status,
	output logic [3:0] rx_signal_buffer_out,
	output logic stack_push,
	output logic [4:0] stack_channel,
	output logic [3:0] stack_abcd,
	// Receive timebase and bus frames
	input wire logic rx_mf_start,
	input wire logic [4:0] slip_frame_delay,
	input wire logic bus_frame_start,
	output logic rx_multiframe_sync,
	output logic [4:0] bus_frame_q,
	output logic reinsert_active,
	input wire logic [4:0] pcm_channel,
	// Slip events
	input wire logic tx_frame_tick,
	input wire logic rx_frame_tick,
	input wire logic tx_ctrl_slip,
	input wire logic tx_unctrl_slip,
	input wire logic tx_slip_repeat,
	input wire logic tx_bus_fast,
	input wire logic rx_ctrl_slip,
	input wire logic rx_unctrl_slip,
	input wire logic rx_slip_repeat,
	input wire logic rx_bus_fast,
	output logic slip_irq_status
);
	logic [4:0] offset_q;
	logic [7:0] sigcr_q;
	logic [7:0] slip_status_q;
	logic [7:0] slip_status_d;
	logic [3:0] sig_buf_q [0:CHANNELS-1];
	logic [3:0] sig_sel;
	logic [4:0] pulse_frame;
	logic [4:0] frame_count;
	logic [4:0] mf_target;
	logic update_all;
	logic pin_d;
	logic status_rd;
	logic wr_offset;
	logic wr_sigcr;
	logic [1:0] tx_class;
	logic [1:0] rx_class;

	// Frame index modulo multiframe length; offset plus delay may pass it twice
	function automatic logic [4:0] wrap_frame(input logic t1, input logic [5:0] v);
		logic [5:0] lim;
		logic [5:0] rem;
		lim = t1 ? {1'b0, `SFSS_T1_FRAMES} : {1'b0, `SFSS_E1_FRAMES};
		rem = v;
		if (rem >= lim)
			rem = rem - lim;
		if (rem >= lim)
			rem = rem - lim;
		wrap_frame = rem[4:0];
	endfunction

	// Register port decode, shared by strobes and read mux
	function automatic logic addr_hit
	(
		input logic [`SFSS_ADDR_W-1:0] a,
		input logic [`SFSS_ADDR_W-1:0] at
	);
		addr_hit = (a == at);
	endfunction

	// Slip classification by buffer mode, as {controlled, uncontrolled}
	function automatic logic [1:0] slip_class
	(
		input sfss_sb_mode_t mode,
		input logic ctrl,
		input logic unctrl,
		input logic bus_fast
	);
		logic short_line_fast;
		logic [1:0] cls;
		short_line_fast = (mode == SFSS_SB_SHORT) && !bus_fast;
		cls = 2'b00;
		if (mode == SFSS_SB_NORMAL || mode == SFSS_SB_SHORT)
			cls[1] = ctrl || (short_line_fast && unctrl);
		if (mode != SFSS_SB_BYPASS)
			cls[0] = unctrl && !short_line_fast;
		slip_class = cls;
	endfunction

	// Freeze decision
	always_comb
	begin
		if (sigcr_q[`SFSS_BIT_RELEASE])
		begin
			pin_d = 1'b0;
			update_all = 1'b1;
		end
		else if (sigcr_q[`SFSS_BIT_FORCE])
		begin
			pin_d = 1'b1;
			update_all = 1'b0;
		end
		else
		begin
			pin_d = auto_freeze;
			update_all = ~auto_freeze;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			signaling_freeze <= 1'b0;
		else
			signaling_freeze <= pin_d;
	end

	// Interrupt source ignores the manual controls
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			freeze_irq_status <= 1'b0;
		else
			freeze_irq_status <= auto_freeze;
	end

	// Per-channel signaling buffer
	generate
		for (genvar ch = 0; ch < CHANNELS; ch++)
		begin : g_sig_buf
			always_ff @(posedge ref_clk)
			begin
				if (sys_rst)
					sig_buf_q[ch] <= 4'h0;
				else if (dbit_update && update_all && dbit_channel == 5'(ch))
					sig_buf_q[ch] <= abcd_in;
			end
		end
	endgenerate

	always_comb
	begin
		sig_sel = sig_buf_q[dbit_channel];
	end

	// Stack push on a changed value of an enabled channel
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			stack_push <= 1'b0;
		else
			stack_push <= dbit_update && update_all && stack_channel_enable[dbit_channel]
				&& (sig_sel != abcd_in);
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			stack_channel <= 5'h00;
			stack_abcd <= 4'h0;
		end
		else
		begin
			stack_channel <= dbit_channel;
			stack_abcd <= abcd_in;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rx_signal_buffer_out <= 4'h0;
		else
			rx_signal_buffer_out <= sig_sel;
	end

	// Multiframe sync placement
	always_comb
	begin
		if (line_rate_select)
			pulse_frame = (offset_q > `SFSS_T1_MAX_OFFSET) ? `SFSS_T1_MAX_OFFSET : offset_q;
		else
			pulse_frame = {1'b0, offset_q[3:0]};
		mf_target = wrap_frame(line_rate_select, {1'b0, pulse_frame} + {1'b0, slip_frame_delay});
		frame_count = line_rate_select ? `SFSS_T1_FRAMES : `SFSS_E1_FRAMES;
	end

	// Transparent mode realigns the bus frame counter
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			bus_frame_q <= 5'h00;
		else if (sigcr_q[`SFSS_BIT_TRANSPARENT] && rx_mf_start)
			bus_frame_q <= mf_target;
		else if (bus_frame_start)
			bus_frame_q <= (bus_frame_q + 5'h01 >= frame_count) ? 5'h00 : bus_frame_q + 5'h01;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rx_multiframe_sync <= 1'b0;
		else
			rx_multiframe_sync <= bus_frame_start && (bus_frame_q == pulse_frame);
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			reinsert_active <= 1'b0;
		else
			reinsert_active <= insert_enable[pcm_channel];
	end

	// Slip status
	always_comb
	begin
		status_rd = reg_rd && addr_hit(reg_addr, `SFSS_ADDR_SLIP_STATUS);
		tx_class = 2'b00;
		if (tx_frame_tick)
			tx_class = slip_class(tx_bus_config, tx_ctrl_slip, tx_unctrl_slip, tx_bus_fast);
		rx_class = 2'b00;
		if (rx_frame_tick)
			rx_class = slip_class(rx_system_bus, rx_ctrl_slip, rx_unctrl_slip, rx_bus_fast);
		slip_status_d = status_rd ? 8'h00 : slip_status_q;
		// Event set wins over the read clear
		if (tx_class[1])
			slip_status_d[`SFSS_SS_TX_CTRL] = 1'b1;
		if (tx_class[0])
			slip_status_d[`SFSS_SS_TX_UNCTRL] = 1'b1;
		if (|tx_class)
			slip_status_d[`SFSS_SS_TX_DIR] = tx_slip_repeat;
		if (rx_class[1])
			slip_status_d[`SFSS_SS_RX_CTRL] = 1'b1;
		if (rx_class[0])
			slip_status_d[`SFSS_SS_RX_UNCTRL] = 1'b1;
		if (|rx_class)
			slip_status_d[`SFSS_SS_RX_DIR] = rx_slip_repeat;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			slip_status_q <= 8'h00;
		else
			slip_status_q <= slip_status_d;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			slip_irq_status <= 1'b0;
		else
			slip_irq_status <= slip_status_d[`SFSS_SS_TX_CTRL] | slip_status_d[`SFSS_SS_TX_UNCTRL]
				| slip_status_d[`SFSS_SS_RX_CTRL] | slip_status_d[`SFSS_SS_RX_UNCTRL];
	end

	// Register write strobes
	always_comb
	begin
		wr_offset = reg_wr && addr_hit(reg_addr, `SFSS_ADDR_OFFSET);
		wr_sigcr = reg_wr && addr_hit(reg_addr, `SFSS_ADDR_SIGCR);
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			offset_q <= `SFSS_OFFSET_RST;
		else if (wr_offset)
			offset_q <= reg_wdata[4:0];
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			sigcr_q <= `SFSS_SIGCR_RST;
		else if (wr_sigcr)
			sigcr_q <= {1'b0, reg_wdata[6:0]};
	end

	// Register reads
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			if (addr_hit(reg_addr, `SFSS_ADDR_OFFSET))
				reg_rdata <= {3'h0, offset_q};
			else if (addr_hit(reg_addr, `SFSS_ADDR_SLIP_STATUS))
				reg_rdata <= slip_status_q;
			else if (addr_hit(reg_addr, `SFSS_ADDR_SIGCR))
				reg_rdata <= sigcr_q;
			else
				reg_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// File: verification/sfss_core_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfss_consts.svh"
module sfss_core_chk
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic [`SFSS_ADDR_W-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic dbit_update,
	input wire logic auto_freeze,
	input wire logic signaling_freeze,
	input wire logic freeze_irq_status,
	input wire logic stack_push,
	input wire logic bus_frame_start,
	input wire logic rx_multiframe_sync,
	input wire logic tx_frame_tick,
	input wire logic rx_frame_tick,
	input wire logic slip_irq_status
);
	wire rd_ss = reg_rd && reg_addr == `SFSS_ADDR_SLIP_STATUS;
	wire no_tick = !tx_frame_tick && !rx_frame_tick;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	chk_read_clears: assert property (rd_ss && no_tick ##1 no_tick |=> !slip_irq_status)
		else $error("status kept");
	chk_flags_hold: assert property (slip_irq_status && !rd_ss && !$past(rd_ss) |=> slip_irq_status)
		else $error("status lost");
	chk_quiet_idle: assert property (!slip_irq_status && no_tick [*2] |=> !slip_irq_status)
		else $error("status between frames");
	chk_mf_frame: assert property (rx_multiframe_sync |-> $past(bus_frame_start))
		else $error("sync off frame");
	chk_mf_single: assert property (rx_multiframe_sync |=> !rx_multiframe_sync)
		else $error("sync twice");
	chk_frozen_quiet: assert property (signaling_freeze && $past(signaling_freeze) |-> !stack_push)
		else $error("push while frozen");
	chk_irq_follows: assert property (1 |=> freeze_irq_status == $past(auto_freeze))
		else $error("freeze irq wrong");
	chk_push_dbit: assert property (stack_push |-> $past(dbit_update))
		else $error("push without dbit");
	cover property (stack_push);
	cover property (rx_multiframe_sync);
	cover property (rd_ss && slip_irq_status);
endmodule
bind sfss_core sfss_core_chk u_chk (.*);
`default_nettype wire

// File: verification/sfss_host.sv
`timescale 1ns/100ps
`default_nettype none
module sfss_host
(
	// Clock
	input wire logic ref_clk,
	// Register port
	output var logic [8:0] reg_addr,
	output var logic reg_wr,
	output var logic reg_rd,
	output var logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// File: verification/sfss_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sfss_core_tb;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic line_rate_select, dbit_update, auto_freeze, rx_mf_start, bus_frame_start, reg_wr;
	logic tx_frame_tick, rx_frame_tick, tx_ctrl_slip, tx_unctrl_slip, tx_slip_repeat, reg_rd;
	logic tx_bus_fast, rx_ctrl_slip, rx_unctrl_slip, rx_slip_repeat, rx_bus_fast, stack_push;
	logic signaling_freeze, freeze_irq_status, rx_multiframe_sync, reinsert_active, slip_irq_status;
	logic [31:0] stack_channel_enable, insert_enable;
	logic [8:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, v;
	logic [4:0] dbit_channel, slip_frame_delay, pcm_channel, stack_channel, bus_frame_q;
	logic [3:0] abcd_in, rx_signal_buffer_out, stack_abcd;
	sfss_pkg::sfss_sb_mode_t tx_bus_config, rx_system_bus;
	int failures = 0, comparisons = 0, pushes = 0, pulses = 0, p0;
	always #50 ref_clk = ~ref_clk;
	sfss_core u_dut (.*);
	sfss_host u_host (.*);
	always @(posedge ref_clk)
	begin
		pushes <= pushes + int'(stack_push);
		pulses <= pulses + int'(rx_multiframe_sync);
	end
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic sig(input logic [7:0] c, input logic [3:0] a, input logic [7:0] f, b, n);
		u_host.wr(9'h0d7, c);
		repeat (2) @(posedge ref_clk);
		p0 = pushes;
		{dbit_update, abcd_in} <= {1'b1, a};
		@(posedge ref_clk);
		dbit_update <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(8'(signaling_freeze), f);
		check(8'(rx_signal_buffer_out), b);
		check(8'(pushes - p0), n);
		check(8'(stack_abcd), 8'(a));
		check(8'(stack_channel), 8'h02);
	endtask
	task automatic ev(input logic [1:0] tm, rm, input logic [3:0] tv, rv, input logic [7:0] e);
		@(posedge ref_clk);
		tx_bus_config <= sfss_pkg::sfss_sb_mode_t'(tm);
		rx_system_bus <= sfss_pkg::sfss_sb_mode_t'(rm);
		{tx_ctrl_slip, tx_unctrl_slip, tx_slip_repeat, tx_bus_fast} <= tv;
		{rx_ctrl_slip, rx_unctrl_slip, rx_slip_repeat, rx_bus_fast} <= rv;
		{tx_frame_tick, rx_frame_tick} <= 2'b11;
		@(posedge ref_clk);
		{tx_frame_tick, rx_frame_tick} <= 2'b00;
		repeat (2) @(posedge ref_clk);
		check(8'(slip_irq_status), 8'(e != 0));
		u_host.rd(9'h0d9, v);
		check(v, e);
		u_host.rd(9'h0d9, v);
		check(v, 8'h00);
	endtask
	task automatic mf(input logic l, input logic [7:0] o, input int n);
		line_rate_select <= l;
		u_host.wr(9'h0d8, o);
		p0 = pulses;
		repeat (n)
		begin
			@(posedge ref_clk);
			bus_frame_start <= 1'b1;
			@(posedge ref_clk);
			bus_frame_start <= 1'b0;
		end
		repeat (3) @(posedge ref_clk);
		check(8'(pulses - p0), 8'h02);
	endtask
	initial
	begin
		{line_rate_select, dbit_update, auto_freeze, rx_mf_start, bus_frame_start} = '0;
		{tx_frame_tick, rx_frame_tick, tx_ctrl_slip, tx_unctrl_slip, tx_slip_repeat} = '0;
		{tx_bus_fast, rx_ctrl_slip, rx_unctrl_slip, rx_slip_repeat, rx_bus_fast} = '0;
		{slip_frame_delay, pcm_channel, abcd_in, insert_enable} = '0;
		{dbit_channel, stack_channel_enable} = {5'h02, 32'h0000_0004};
		{tx_bus_config, rx_system_bus} = '0;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		u_host.rd(9'h0d8, v);
		check(v, 8'h00);
		u_host.wr(9'h0d5, 8'hff);
		u_host.rd(9'h0d5, v);
		check(v, 8'h00);
		$display("register test done");
		sig(8'h00, 4'h5, 8'h01 - 8'h01, 8'h05, 8'h01);
		sig(8'h02, 4'ha, 8'h01, 8'h05, 8'h00);
		sig(8'h06, 4'ha, 8'h00, 8'h0a, 8'h01);
		auto_freeze <= 1'b1;
		sig(8'h00, 4'h3, 8'h01, 8'h0a, 8'h00);
		sig(8'h04, 4'h3, 8'h00, 8'h03, 8'h01);
		check(8'(freeze_irq_status), 8'h01);
		auto_freeze <= 1'b0;
		$display("freeze test done");
		ev(2'h0, 2'h0, 4'he, 4'ha, 8'hec);
		ev(2'h2, 2'h3, 4'hc, 4'hc, 8'h20);
		ev(2'h3, 2'h1, 4'hc, 4'h5, 8'h02);
		ev(2'h1, 2'h1, 4'h4, 4'h4, 8'h44);
		ev(2'h0, 2'h2, 4'h0, 4'hc, 8'h02);
		fork
			u_host.rd(9'h0d9, v);
			begin
				@(posedge ref_clk);
				{tx_ctrl_slip, tx_frame_tick} <= 2'b11;
				@(posedge ref_clk);
				tx_frame_tick <= 1'b0;
			end
		join
		u_host.rd(9'h0d9, v);
		check(v, 8'h40);
		$display("slip test done");
		mf(1'b0, 8'h1f, 32);
		mf(1'b1, 8'h17, 48);
		rx_system_bus <= sfss_pkg::SFSS_SB_BYPASS;
		slip_frame_delay <= 5'h02;
		u_host.wr(9'h0d7, 8'h01);
		rx_mf_start <= 1'b1;
		@(posedge ref_clk);
		rx_mf_start <= 1'b0;
		@(posedge ref_clk);
		check(8'(bus_frame_q), 8'h01);
		mf(1'b1, 8'h17, 48);
		{insert_enable, pcm_channel} <= {32'h0000_0020, 5'h05};
		repeat (2) @(posedge ref_clk);
		check(8'(reinsert_active), 8'h01);
		pcm_channel <= 5'h06;
		repeat (2) @(posedge ref_clk);
		check(8'(reinsert_active), 8'h00);
		$display("sync test done");
		test_done();
	end
	initial
	begin
		#1000000;
		failures++;
		test_done();
	end
endmodule
`default_nettype wire
